//--- hdl/wdt_divider.sv
`timescale 1ns/1ns
`default_nettype none
// free counter that pulses once every div_n enabled ticks; sync clear
module wdt_divider #(
   parameter int W = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clr,
   input wire logic en,
   input wire logic [W-1:0] div_n,
   output logic tick
);
   logic [W-1:0] cnt_q;

   // tick is combinational so the following stage sees it in the same cycle
   assign tick = en && !clr && (cnt_q == div_n - W'(1));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (clr) begin
         cnt_q <= '0;
      end else if (en) begin
         cnt_q <= tick ? '0 : cnt_q + W'(1);
      end
   end
endmodule
`default_nettype wire

//--- hdl/wdt_top.sv
`timescale 1ns/1ns
`default_nettype none
module wdt_top
   import wdt_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] addr,
   input wire logic [RC_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [RC_W-1:0] rdata,
   input wire wdt_cpu_evt_t cpu_evt,
   output logic wdt_reset,
   output logic wake_up,
   output logic rc_enable,
   output logic irq
);
   logic [CFG_W-1:0] cfg_q;
   logic [RC_W-1:0] reset_control_reg_q;
   logic [1:0] stat_q, mask_q;
   logic asleep_q, in_idle_q;
   logic reset_q, wake_q;
   wdt_state_t state_q, state_d;
   logic enabled, wdt_clr, rc_tick, pre_tick, to_evt, early;
   logic [POST_MAX_W-1:0] post_cnt_q, post_target, quarter;
   logic [7:0] pre_n;

   // hard fuse overrides software enable; the rc source follows the watchdog
   assign enabled = cfg_q[CFG_FUSE_BIT] | reset_control_reg_q[RC_SWEN_BIT];
   assign rc_enable = enabled;

   // any listed event restarts rc divider, prescaler and postscaler together
   assign wdt_clr = cpu_evt.clear_watchdog_instr | cpu_evt.power_save_instr |
                    cpu_evt.clock_switch_done | wake_q | cpu_evt.wake_other |
                    !enabled;

   // the rc source is modelled as an enable pulse from the system clock
   wdt_divider #(.W(16)) u_rc (
      .clock(clock),
      .rst_n(rst_n),
      .clr(wdt_clr),
      .en(enabled),
      .div_n(16'(RC_DIV)),
      .tick(rc_tick)
   );

   assign pre_n = cfg_q[CFG_PRE_BIT] ? 8'(PRE_LONG) : 8'(PRE_SHORT);

   // 32 or 128 rc ticks give the 1 ms or 4 ms base period
   wdt_divider #(.W(8)) u_pre (
      .clock(clock),
      .rst_n(rst_n),
      .clr(wdt_clr),
      .en(rc_tick),
      .div_n(pre_n),
      .tick(pre_tick)
   );

   // ratio is two to the power of the code; 1111 gives 32768
   assign post_target = POST_MAX_W'(1) << cfg_q[CFG_POST_LSB +: CFG_POST_W];
   assign quarter = post_target - (post_target >> 2);

   // postscaler counts prescaler periods up to the selected ratio
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         post_cnt_q <= '0;
      end else if (wdt_clr || to_evt) begin
         post_cnt_q <= '0;
      end else if (pre_tick) begin
         post_cnt_q <= post_cnt_q + POST_MAX_W'(1);
      end
   end

   assign to_evt = pre_tick && (post_cnt_q == post_target - POST_MAX_W'(1));

   // early clear: window mode and not yet in the final quarter; ratios below 1:4
   // have no whole quarter, so every clear is early there
   assign early = cpu_evt.clear_watchdog_instr && !cfg_q[CFG_WINDOW_DISABLE_BIT] &&
                  enabled && !asleep_q && (post_cnt_q < quarter);

   // state: off, counting in run mode, counting while low power, biting
   always_comb begin
      state_d = state_q;
      case (state_q)
         WDT_OFF: if (enabled) state_d = WDT_RUN;
         WDT_RUN: begin
            if (!enabled) state_d = WDT_OFF;
            else if (early || to_evt) state_d = WDT_BITE;
            else if (cpu_evt.power_save_instr) state_d = WDT_LOW;
         end
         WDT_LOW: begin
            if (!enabled) state_d = WDT_OFF;
            else if (to_evt || cpu_evt.wake_other) state_d = WDT_RUN;
         end
         WDT_BITE: state_d = WDT_RUN;
         default: state_d = WDT_OFF;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) state_q <= WDT_OFF;
      else state_q <= state_d;
   end

   // one-cycle device reset and wake pulses, registered
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         reset_q <= (state_q == WDT_RUN) && (early || to_evt);
         wake_q <= (state_q == WDT_LOW) && to_evt;
      end
   end
   assign wdt_reset = reset_q;
   assign wake_up = wake_q;
   assign asleep_q = (state_q == WDT_LOW);

   // remember which power-save mode was entered for the status bits
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) in_idle_q <= 1'b0;
      else if (cpu_evt.power_save_instr) in_idle_q <= cpu_evt.idle_select;
   end

   // reset control register: hardware sets win over software writes
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_control_reg_q <= RESET_CONTROL_REG_RESET;
      end else begin
         if (wr_en && addr == ADDR_RESET_CONTROL_REG) reset_control_reg_q <= wdata & 8'h3C;
         if (reset_q) reset_control_reg_q[RC_SWEN_BIT] <= 1'b0;
         if (cpu_evt.power_save_instr && enabled) begin
            if (cpu_evt.idle_select) reset_control_reg_q[RC_IDLE_BIT] <= 1'b1;
            else reset_control_reg_q[RC_SLEEP_BIT] <= 1'b1;
         end
         // sleep/idle stay set after wake; software clears them
         if (wake_q) reset_control_reg_q[in_idle_q ? RC_IDLE_BIT : RC_SLEEP_BIT] <= 1'b1;
         if (to_evt || early) reset_control_reg_q[RC_TO_BIT] <= 1'b1;
      end
   end

   // configuration word is writable here; fuses are loaded by software
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) cfg_q <= CFG_RESET;
      else if (wr_en && addr == ADDR_CFG) cfg_q <= wdata[CFG_W-1:0];
   end

   // interrupt status: write one to clear, set wins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= IRQ_RESET;
         mask_q <= IRQ_RESET;
      end else begin
         if (wr_en && addr == ADDR_IRQ_MASK) mask_q <= wdata[1:0];
         stat_q <= (stat_q & ~((wr_en && addr == ADDR_IRQ_STAT) ? wdata[1:0] : 2'h0))
                   | {early, to_evt};
      end
   end
   assign irq = |(stat_q & mask_q);

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (rd_en) begin
         case (addr)
            ADDR_RESET_CONTROL_REG: rdata <= reset_control_reg_q;
            ADDR_CFG: rdata <= {1'b0, cfg_q};
            ADDR_IRQ_STAT: rdata <= {6'h00, stat_q};
            ADDR_IRQ_MASK: rdata <= {6'h00, mask_q};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // a run-mode timeout is followed by a reset pulse and a set flag
   a_timeout_bite: assert property (@(posedge clock) disable iff (!rst_n)
      (to_evt && state_q == WDT_RUN) |=> (wdt_reset && reset_control_reg_q[RC_TO_BIT]))
      else $error("run timeout gave no reset");
   a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
      (reset_control_reg_q[RC_TO_BIT] && !(wr_en && addr == ADDR_RESET_CONTROL_REG)) |=> reset_control_reg_q[RC_TO_BIT])
      else $error("timeout flag dropped");
   a_sleep_wake: assert property (@(posedge clock) disable iff (!rst_n)
      (to_evt && state_q == WDT_LOW) |=> (wake_up && !wdt_reset))
      else $error("sleep timeout did not wake");
   a_early_clear: assert property (@(posedge clock) disable iff (!rst_n)
      early |=> wdt_reset)
      else $error("early clear gave no reset");
   a_fuse_on: assert property (@(posedge clock) disable iff (!rst_n)
      cfg_q[CFG_FUSE_BIT] |-> rc_enable)
      else $error("fuse set but watchdog off");
   a_soft_off: assert property (@(posedge clock) disable iff (!rst_n)
      (!cfg_q[CFG_FUSE_BIT] && !reset_control_reg_q[RC_SWEN_BIT]) |=> (post_cnt_q == '0))
      else $error("counter moved while disabled");
   a_clear_count: assert property (@(posedge clock) disable iff (!rst_n)
      cpu_evt.clear_watchdog_instr |=> (post_cnt_q == '0))
      else $error("clear did not reset count");
   a_nowin_safe: assert property (@(posedge clock) disable iff (!rst_n)
      (cfg_q[CFG_WINDOW_DISABLE_BIT] && cpu_evt.clear_watchdog_instr && !to_evt) |=> !wdt_reset)
      else $error("clear reset in non-window mode");
endmodule
`default_nettype wire

//--- pkg/wdt_pkg.sv
package wdt_pkg;
   // watchdog configuration word field positions
   localparam int CFG_POST_LSB = 0;
   localparam int CFG_POST_W = 4;
   localparam int CFG_PRE_BIT = 4;
   localparam int CFG_FUSE_BIT = 5;
   localparam int CFG_WINDOW_DISABLE_BIT = 6;
   localparam int CFG_W = 7;
   // reset control register layout
   localparam int RC_IDLE_BIT = 2;
   localparam int RC_SLEEP_BIT = 3;
   localparam int RC_TO_BIT = 4;
   localparam int RC_SWEN_BIT = 5;
   localparam int RC_W = 8;
   // register offsets
   localparam logic [3:0] ADDR_RESET_CONTROL_REG = 4'h0;
   localparam logic [3:0] ADDR_CFG = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
   // reset values
   localparam logic [RC_W-1:0] RESET_CONTROL_REG_RESET = 8'h00;
   localparam logic [CFG_W-1:0] CFG_RESET = 7'h7F;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // timing: the low-power rc source nominal rate against the system clock
   localparam int SYS_CLK_KHZ = 125000;
   localparam int RC_CLK_KHZ = 32;
   localparam int RC_DIV = SYS_CLK_KHZ / RC_CLK_KHZ;
   localparam int PRE_SHORT = 32;
   localparam int PRE_LONG = 128;
   localparam int POST_MAX_W = 16;
   // interrupt status bits
   localparam int IRQ_TIMEOUT = 0;
   localparam int IRQ_EARLY = 1;

   typedef enum logic [3:0] {
      WDT_OFF = 4'h1,
      WDT_RUN = 4'h2,
      WDT_LOW = 4'h4,
      WDT_BITE = 4'h8
   } wdt_state_t;

   typedef struct packed {
      logic clear_watchdog_instr;
      logic power_save_instr;
      logic idle_select;
      logic wake_other;
      logic clock_switch_done;
   } wdt_cpu_evt_t;
endpackage

//--- testbench/tb_wdt_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_wdt_top
   import wdt_pkg::*;
;
   logic clock, rst_n, wr_en, rd_en, wake_up, wdt_reset, rc_enable, irq;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, d, c, r;
   wdt_cpu_evt_t cpu_evt;
   int fails, n_compared, n_reset, cyc, n, per;
   logic [31:0] lfsr_q;

   wdt_top dut_u (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .cpu_evt(cpu_evt), .wdt_reset(wdt_reset),
      .wake_up(wake_up), .rc_enable(rc_enable), .irq(irq));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // reset pulses counted apart so a stray one during sleep is seen
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (wdt_reset === 1'b1) n_reset <= n_reset + 1;
      if (cyc == 400000) begin
         fails = fails + 1;
         print_verdict();
      end
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // expected timeout in clocks for a configuration word
   function automatic int period(input logic [7:0] cw);
      return RC_DIV * (cw[CFG_PRE_BIT] ? PRE_LONG : PRE_SHORT) * (1 << cw[3:0]);
   endfunction

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared = n_compared + 1;
      if (g !== e) begin
         fails = fails + 1;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic evt(input logic [4:0] v);
      @(posedge clock);
      cpu_evt <= wdt_cpu_evt_t'(v);
      @(posedge clock);
      cpu_evt <= '0;
   endtask

   // bounded wait for a pulse: sel 0 device reset, 1 wake
   // the pulse may already stand right after the event task returns, so look first
   task automatic wait_out(input int sel, input int lim, output int k);
      k = 0;
      #1;
      while (k < lim && (sel == 0 ? wdt_reset : wake_up) !== 1'b1) begin
         @(posedge clock);
         #1 k = k + 1;
      end
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      {wr_en, rd_en, addr, wdata, fails, n_compared, n_reset, cyc} = '0;
      cpu_evt = '0;
      lfsr_q = 32'h22A2;
      rst_n = 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      rd(ADDR_RESET_CONTROL_REG, d); chk("reset_control_reg reset", 8'h00, d);
      rd(ADDR_CFG, d); chk("cfg reset", 8'h7F, d);
      rd(4'h2, d); chk("unmapped read", 8'h00, d);
      chk("rc on by fuse", 8'h01, {7'h00, rc_enable});
      // random fuse and soft enable mixes
      for (int i = 0; i < 12; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         c = {1'b0, lfsr_q[6:0]};
         r = lfsr_q[15:8];
         wr(ADDR_CFG, c);
         wr(ADDR_RESET_CONTROL_REG, r);
         wr(4'h2, 8'hFF);
         rd(ADDR_RESET_CONTROL_REG, d); chk("reset_control_reg rw", r & 8'h3C, d);
         rd(ADDR_CFG, d); chk("cfg rw", c, d);
         chk("rc enable", {7'h00, c[5] | r[5]}, {7'h00, rc_enable});
      end
      // window mode, divide 32, 1:1: every clear is early
      wr(ADDR_CFG, 8'h00);
      wr(ADDR_RESET_CONTROL_REG, 8'h20);
      wr(ADDR_IRQ_STAT, 8'h03);
      evt(5'h10);
      wait_out(0, 4, n); chk("early clear reset", 8'h01, {7'h00, n < 4});
      rd(ADDR_RESET_CONTROL_REG, d); chk("early flag", 8'h10, d);
      rd(ADDR_IRQ_STAT, d); chk("early stat", 8'h02, d & 8'h02);
      wr(ADDR_IRQ_MASK, 8'h02);
      @(negedge clock);
      chk("irq up", 8'h01, {7'h00, irq});
      wr(ADDR_IRQ_STAT, 8'h02);
      @(negedge clock);
      chk("irq cleared", 8'h00, {7'h00, irq});
      // non-window run timeout, restarted by a clock switch
      c = 8'h40;
      per = period(c);
      wr(ADDR_CFG, c);
      wr(ADDR_RESET_CONTROL_REG, 8'h20);
      evt(5'h10);
      n = n_reset;
      repeat (20000) @(posedge clock);
      chk("no early timeout", 8'h00, 8'(n_reset - n));
      evt(5'h01);
      wait_out(0, per + 10, n);
      chk("run timeout near", 8'h01, {7'h00, n >= per - 3 && n <= per + 3});
      // the watchdog reset drops the soft enable, so only the flag remains
      rd(ADDR_RESET_CONTROL_REG, d); chk("timeout flag", 8'h10, d);
      evt(5'h10);
      rd(ADDR_RESET_CONTROL_REG, d); chk("flag sticky", 8'h10, d);
      // sleep: timeout wakes instead of resetting; re-enable, keep the flag
      wr(ADDR_RESET_CONTROL_REG, 8'h30);
      n_reset = 0;
      evt(5'h08);
      wait_out(1, per + 10, n);
      chk("sleep wake time", 8'h01, {7'h00, n >= per - 3 && n <= per + 3});
      chk("no reset asleep", 8'h00, 8'(n_reset));
      rd(ADDR_RESET_CONTROL_REG, d); chk("sleep bit kept", 8'h38, d);
      wr(ADDR_RESET_CONTROL_REG, 8'h20);
      rd(ADDR_RESET_CONTROL_REG, d); chk("sleep bit cleared", 8'h20, d);
      // a second reset drops the soft enable
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      rd(ADDR_RESET_CONTROL_REG, d); chk("soft enable reset", 8'h00, d);
      print_verdict();
   end
endmodule
`default_nettype wire
